// file: design/bct_regs.v
// AXI4-Lite register bank for board configuration transfers
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "bct_defines.vh"

module bct_regs (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [5:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [5:0]  s_axi_araddr,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Transfer engine request
    output reg         xfer_req_r,
    output reg  [31:0] xfer_ctrl_r,
    output reg  [31:0] xfer_wdata_r,
    // Transfer engine answer
    input  wire        xfer_done,
    input  wire        xfer_err,
    input  wire [31:0] xfer_rdata,
    // Video settings
    output reg  [1:0]  video_source_r,
    output reg  [2:0]  video_mode_r,
    // Interrupt
    output reg         irq_r
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [31:0] data_r;
    reg  [31:0] ctrl_r;
    reg  [1:0]  stat_r;
    reg  [1:0]  irq_stat_r;
    reg  [1:0]  irq_en_r;
    reg         aw_held_r;
    reg  [5:0]  aw_addr_r;
    reg         w_held_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;

    wire        aw_take = s_axi_awvalid & s_axi_awready;
    wire        w_take  = s_axi_wvalid & s_axi_wready;
    wire        have_aw = aw_held_r | aw_take;
    wire        have_w  = w_held_r | w_take;
    wire [5:0]  wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire        wr_go   = have_aw & have_w & ~s_axi_bvalid;
    wire        busy    = ctrl_r[`BCT_CTRL_START];
    wire        fin     = busy & (xfer_done | xfer_err);

    // ----------------------------------------
    // Byte-lane merge
    // ----------------------------------------
    wire [31:0] data_mrg;
    wire [31:0] ctrl_mrg;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign data_mrg[g*8 +: 8] = wr_strb[g] ? wr_data[g*8 +: 8] : data_r[g*8 +: 8];
            assign ctrl_mrg[g*8 +: 8] = wr_strb[g] ? wr_data[g*8 +: 8] : ctrl_r[g*8 +: 8];
        end
    endgenerate

    wire [31:0] ctrl_new = ctrl_mrg & `BCT_CTRL_MASK;
    wire        wr_ctrl  = wr_go & (wr_addr == `BCT_OFF_CTRL);
    wire        start_wr = wr_ctrl & ~busy & ctrl_new[`BCT_CTRL_START];
    wire [5:0]  fn_new   = ctrl_new[`BCT_CTRL_FN_HI:`BCT_CTRL_FN_LO];
    wire [31:0] wd_eff   = (wr_go & (wr_addr == `BCT_OFF_DATA))
                           ? data_mrg : data_r;

    // ----------------------------------------
    // Write response select
    // ----------------------------------------
    reg  [1:0]  wr_resp_nxt;

    always @* begin
        case (wr_addr)
            `BCT_OFF_DATA, `BCT_OFF_CTRL, `BCT_OFF_STAT, `BCT_OFF_IRQ_CLR,
            `BCT_OFF_IRQ_EN, `BCT_OFF_VIDEO: wr_resp_nxt = 2'h0;
            default: wr_resp_nxt = 2'h2;
        endcase
    end

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_held_r     <= 1'b0;
            aw_addr_r     <= 6'h00;
            w_held_r      <= 1'b0;
            w_data_r      <= `BCT_RST_WORD;
            w_strb_r      <= 4'h0;
        end else begin
            s_axi_awready <= ~have_aw & ~s_axi_awready & ~(s_axi_bvalid & ~s_axi_bready);
            s_axi_wready  <= ~have_w & ~s_axi_wready & ~(s_axi_bvalid & ~s_axi_bready);
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r     <= 1'b0;
                w_held_r      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_resp_nxt;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Register write decode
    // ----------------------------------------
    wire        sel_data = wr_go & (wr_addr == `BCT_OFF_DATA);
    wire        sel_stat = wr_go & (wr_addr == `BCT_OFF_STAT);
    wire        sel_clr  = wr_go & (wr_addr == `BCT_OFF_IRQ_CLR);
    wire        sel_en   = wr_go & (wr_addr == `BCT_OFF_IRQ_EN);
    wire        vsrc_ok  = ctrl_new[`BCT_CTRL_WRITE] & (fn_new == `BCT_FN_VSRC)
                           & (wd_eff[1:0] != `BCT_VSRC_UNUSED);
    wire        vmode_ok = ctrl_new[`BCT_CTRL_WRITE] & (fn_new == `BCT_FN_VMODE)
                           & (wd_eff[2:0] <= `BCT_VMODE_MAX);
    wire [1:0]  irq_set  = {fin & xfer_err, fin};
    wire [1:0]  irq_clr  = sel_clr ? wr_data[1:0] : 2'h0;

    // ----------------------------------------
    // Data register
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            data_r <= `BCT_RST_WORD;
        end else if (fin & ~ctrl_r[`BCT_CTRL_WRITE] & ~xfer_err) begin
            data_r <= xfer_rdata;
        end else if (sel_data) begin
            data_r <= data_mrg;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `BCT_RST_WORD;
        end else if (fin) begin
            ctrl_r[`BCT_CTRL_START] <= 1'b0;
        end else if (wr_ctrl & ~busy) begin
            ctrl_r <= ctrl_new;
        end
    end

    // ----------------------------------------
    // Transfer request
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            xfer_req_r   <= 1'b0;
            xfer_ctrl_r  <= `BCT_RST_WORD;
            xfer_wdata_r <= `BCT_RST_WORD;
        end else begin
            xfer_req_r <= start_wr;
            if (start_wr) begin
                xfer_ctrl_r  <= ctrl_new;
                xfer_wdata_r <= wd_eff;
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 2'h0;
        end else if (fin) begin
            stat_r <= {xfer_err, 1'b1};
        end else if (start_wr) begin
            stat_r <= 2'h0;
        end else if (sel_stat) begin
            stat_r <= stat_r & wr_data[1:0];
        end
    end

    // ----------------------------------------
    // Video settings
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            video_source_r <= `BCT_RST_VSRC;
            video_mode_r   <= `BCT_RST_VMODE;
        end else if (start_wr) begin
            if (vsrc_ok) begin
                video_source_r <= wd_eff[1:0];
            end
            if (vmode_ok) begin
                video_mode_r <= wd_eff[2:0];
            end
        end
    end

    // ----------------------------------------
    // Interrupt status, enable and output
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= 2'h0;
            irq_en_r   <= 2'h0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            if (sel_en) begin
                irq_en_r <= wr_data[1:0];
            end
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    // ----------------------------------------
    // Read data select
    // ----------------------------------------
    reg  [31:0] rd_word_nxt;
    reg  [1:0]  rd_resp_nxt;

    always @* begin
        rd_word_nxt = `BCT_RST_WORD;
        rd_resp_nxt = 2'h0;
        case (s_axi_araddr)
            `BCT_OFF_DATA:     rd_word_nxt = data_r;
            `BCT_OFF_CTRL:     rd_word_nxt = ctrl_r;
            `BCT_OFF_STAT:     rd_word_nxt = {30'h0, stat_r};
            `BCT_OFF_IRQ_STAT: rd_word_nxt = {30'h0, irq_stat_r};
            `BCT_OFF_IRQ_CLR:  rd_word_nxt = `BCT_RST_WORD;
            `BCT_OFF_IRQ_EN:   rd_word_nxt = {30'h0, irq_en_r};
            `BCT_OFF_VIDEO:    rd_word_nxt = {27'h0, video_mode_r, video_source_r};
            default:           rd_resp_nxt = 2'h2;
        endcase
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `BCT_RST_WORD;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word_nxt;
                s_axi_rresp   <= rd_resp_nxt;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: design/bct_defines.vh
// Offsets, fields, reset values and codes for the config transfer registers
`ifndef BCT_DEFINES_VH
`define BCT_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BCT_OFF_DATA      6'h00
`define BCT_OFF_CTRL      6'h04
`define BCT_OFF_STAT      6'h08
`define BCT_OFF_IRQ_STAT  6'h0C
`define BCT_OFF_IRQ_CLR   6'h10
`define BCT_OFF_IRQ_EN    6'h14
`define BCT_OFF_VIDEO     6'h18

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define BCT_CTRL_START    31
`define BCT_CTRL_WRITE    30
`define BCT_CTRL_CTL_HI   29
`define BCT_CTRL_CTL_LO   26
`define BCT_CTRL_FN_HI    25
`define BCT_CTRL_FN_LO    20
`define BCT_CTRL_SITE_HI  17
`define BCT_CTRL_SITE_LO  16
`define BCT_CTRL_POS_HI   15
`define BCT_CTRL_POS_LO   12
`define BCT_CTRL_DEV_HI   11
`define BCT_CTRL_DEV_LO   0
`define BCT_CTRL_MASK     32'hFFF3FFFF

// ----------------------------------------
// Status fields
// ----------------------------------------
`define BCT_STAT_DONE     0
`define BCT_STAT_ERR      1

// ----------------------------------------
// Function codes
// ----------------------------------------
`define BCT_FN_OSC        6'h01
`define BCT_FN_VOLT       6'h02
`define BCT_FN_AMP        6'h03
`define BCT_FN_TEMP       6'h04
`define BCT_FN_RESET      6'h05
`define BCT_FN_SCC        6'h06
`define BCT_FN_VSRC       6'h07
`define BCT_FN_SHUTDOWN   6'h08
`define BCT_FN_REBOOT     6'h09
`define BCT_FN_VMODE      6'h0B
`define BCT_FN_POWER      6'h0C
`define BCT_FN_ENERGY     6'h0D

// ----------------------------------------
// Video encodings and reset values
// ----------------------------------------
`define BCT_VSRC_UNUSED   2'h3
`define BCT_VMODE_MAX     3'h4
`define BCT_RST_WORD      32'h00000000
`define BCT_RST_VSRC      2'h0
`define BCT_RST_VMODE     3'h0

`endif

// file: bench/bct_engine_model.sv
// Transfer engine model answering the register bank
`timescale 1ns/1ns
module bct_engine_model (
    // Clock and reset
    input  logic        aclk,
    input  logic        aresetn,
    // Request
    input  logic        req,
    input  logic [31:0] ctrl,
    input  logic        fail,
    input  logic [3:0]  lag,
    // Answer
    output logic        done,
    output logic        err,
    output logic [31:0] rdata
);
    logic [4:0] cnt_r;
    // -----------------
    // Delayed answer
    // -----------------
    always @(posedge aclk) begin
        done <= 1'b0;
        err <= 1'b0;
        rdata <= ~rdata;
        if (!aresetn) begin
            cnt_r <= 5'h00;
            rdata <= 32'h00000000;
        end else if (req) begin
            cnt_r <= {1'b0, lag} + 5'h01;
        end else if (cnt_r == 5'h01) begin
            cnt_r <= 5'h00;
            done <= !fail;
            err <= fail;
            rdata <= ~ctrl;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule

// file: bench/bct_regs_props.sv
// Checker for the config transfer register bank
`timescale 1ns/1ns
module bct_regs_props (
    // Clock, reset and bus
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awready,
    input logic        s_axi_bvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    // Transfer and video
    input logic        xfer_req_r,
    input logic [31:0] xfer_ctrl_r,
    input logic        xfer_done,
    input logic        xfer_err,
    input logic [1:0]  video_source_r,
    input logic [2:0]  video_mode_r
);
    logic busy_r;
    always @(posedge aclk) begin
        if (!aresetn) busy_r <= 1'b0;
        else if (xfer_req_r) busy_r <= 1'b1;
        else if (xfer_done || xfer_err) busy_r <= 1'b0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    start_bit_a: assert property (xfer_req_r |-> xfer_ctrl_r[31])
        else $error("request without start bit");
    no_restart_a: assert property (xfer_req_r |-> !busy_r)
        else $error("restart while busy");
    req_pulse_a: assert property (xfer_req_r |=> !xfer_req_r)
        else $error("request longer than one cycle");
    ctrl_hold_a: assert property (busy_r |-> $stable(xfer_ctrl_r))
        else $error("control word moved while busy");
    vsrc_valid_a: assert property (video_source_r != 2'h3)
        else $error("unused video source taken");
    vmode_valid_a: assert property (video_mode_r <= 3'h4)
        else $error("video mode out of range");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address ready during response");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready during read data");
    cover property (xfer_req_r);
    cover property (busy_r && xfer_err);
    cover property (busy_r && xfer_done);
endmodule

// file: bench/tb.sv
// Testbench for the config transfer register bank
`timescale 1ns/1ns
module tb;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, fail = 0;
    logic [5:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, q, st, rd_d, ctl, wdo, xrd;
    logic [3:0]  lag = 4'hF;
    logic        awr, wrdy, bv, arr, rv, req, done, err, irq;
    logic [1:0]  br, vsrc, rr, rsp;
    logic [2:0]  vmode;
    logic [5:0]  fns[6] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h0C, 6'h0D};
    int          n_fail = 0, compares = 0;
    bct_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .xfer_req_r(req),
        .xfer_ctrl_r(ctl), .xfer_wdata_r(wdo), .xfer_done(done), .xfer_err(err),
        .xfer_rdata(xrd), .video_source_r(vsrc), .video_mode_r(vmode), .irq_r(irq));
    bct_engine_model eng (.aclk(aclk), .aresetn(aresetn), .req(req), .ctrl(ctl),
        .fail(fail), .lag(lag), .done(done), .err(err), .rdata(xrd));
    initial forever #2 aclk = ~aclk;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task hang(input int n);
        if (n >= 60) begin
            n_fail++;
            close_out;
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv && n < 60);
        chk("bresp", {30'h0, br}, {30'h0, e});
        bry <= 1'b0;
        hang(bv ? 0 : n);
        @(posedge aclk);
    endtask
    task rd(input logic [5:0] a, output logic [31:0] d);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 60);
        d = rd_d;
        rsp = rr;
        rry <= 1'b0;
        hang(rv ? 0 : n);
        @(posedge aclk);
    endtask
    task xfer(input logic [31:0] c, input logic [31:0] d, input logic f, input logic cl);
        int n;
        n = 0;
        fail <= f;
        rd(6'h04, q);
        chk("busy", q & 32'h80000000, 32'h0);
        if (cl) wr(6'h08, 32'h0, 2'h0);
        if (c[30]) wr(6'h00, d, 2'h0);
        wr(6'h04, c, 2'h0);
        rd(6'h04, q);
        chk("ctrl", q, c);
        wr(6'h04, 32'hC0700002, 2'h0);
        chk("ctl", ctl, c);
        rd(6'h08, q);
        chk("stat_clr", q, 32'h0);
        do begin
            rd(6'h08, st);
            n++;
        end while (!st[0] && n < 60);
        hang(st[0] ? 0 : n);
        rd(6'h04, q);
        chk("start", q & 32'h80000000, 32'h0);
        chk("stat", st, {30'h0, f, 1'b1});
        rd(6'h00, q);
        if (!c[30] && !f) chk("rdata", q, ~c);
        if (c[30]) chk("wdata", wdo, d);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(6'h04, q);
        chk("ctrl_rst", q, 32'h0);
        chk("rresp_ok", {30'h0, rsp}, 32'h0);
        wr(6'h14, 32'h3, 2'h0);
        foreach (fns[i]) xfer({2'b11, 4'h0, fns[i], 20'h1}, 32'h02FAF080 + 32'(i), 0, 1);
        xfer(32'h80213005, 32'h0, 1'b0, 1'b1);
        xfer(32'h80213005, 32'h0, 1'b1, 1'b1);
        chk("irq_on", {31'h0, irq}, 32'h1);
        xfer(32'h80213005, 32'h0, 1'b0, 1'b0);
        wr(6'h10, 32'h3, 2'h0);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        wr(6'h14, 32'h0, 2'h0);
        xfer(32'h80213005, 32'h0, 1'b1, 1'b1);
        chk("irq_mask", {31'h0, irq}, 32'h0);
        rd(6'h0C, q);
        chk("irq_stat", q & 32'h2, 32'h2);
        for (int i = 0; i < 4; i++) begin
            xfer({2'b11, 4'h0, (i > 1) ? 6'h0B : 6'h07, 20'h0}, 32'h2 + 32'(i), 0, 1);
            chk("vsrc", {30'h0, vsrc}, 32'h2);
            chk("vmode", {29'h0, vmode}, (i > 1) ? 32'h4 : 32'h0);
        end
        rd(6'h18, q);
        chk("video", q, 32'h12);
        wr(6'h3C, 32'h1, 2'h2);
        rd(6'h3C, q);
        chk("unmapped", q, 32'h0);
        chk("rresp_err", {30'h0, rsp}, 32'h2);
        close_out;
    end
endmodule
bind bct_regs bct_regs_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .xfer_req_r(xfer_req_r),
    .xfer_ctrl_r(xfer_ctrl_r), .xfer_done(xfer_done), .xfer_err(xfer_err),
    .video_source_r(video_source_r), .video_mode_r(video_mode_r));
